/* rtl/rtcw_window_access.sv */
// Behaviour
// - Value pointer picks time pair: 00 min/sec, 01 wday/hour, 10 month/day, 11 year.
// - High-byte write of time window decrements value pointer, sticking at 00.
// - Alarm pointer picks alarm pair: 00 min/sec, 01 wday/hour, 10 month/day, 11 none.
// - High-byte write of alarm window decrements alarm pointer, sticking at 00.
// - Any read of alarm window, either byte, decrements the alarm pointer.
// - Any read of time window, either byte, decrements the value pointer.
// - Low-byte writes leave both pointers unchanged.
// - Time registers accept writes only while the time write enable is set.
// - Write enable can be set only right after key writes 0x55 then 0xAA.
// - Pad select bit 1 chooses seconds clock, else alarm pulse, for the pin.
// - The pin carries the selected signal only while the output enable is set.
// - Calibration/configuration register is reset only by power-on reset.
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ns
module rtcw_window_access (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        softRst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  input  wire logic        secClk,
  input  wire logic        alarmPulse,
  input  wire logic        halfSec,
  input  wire logic        syncBusy,
  output logic             rtcEnable,
  output logic      [7:0]  driftCal,
  output logic      [15:0] alarmConfig,
  output logic      [63:0] timeValues,
  output logic      [63:0] alarmValues,
  output logic             pinOut,
  output logic             pinOe
);

  // One address compare, shared by every register select
  function automatic logic hitOfs(input logic [7:0] addr,
                                  input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  // A window access moves its pointer on any read, or on a write with the high byte
  function automatic logic winStep(input logic rdHit,
                                   input logic wrHit,
                                   input logic hiLane);
    return rdHit | (wrHit & hiLane);
  endfunction

  // Bus phase decode
  logic        setupRead;
  logic        accDone;
  logic        wrDone;
  logic        rdDone;
  logic        selCalib;
  logic        selAlarmCfg;
  logic        selTimeWin;
  logic        selAlarmWin;
  logic        selKey;
  logic        selPad;
  logic        mapped;

  // Register state
  logic [15:0] calib_r;
  logic [15:0] calib_nxt;
  logic [15:0] alarmCfg_r;
  logic [15:0] alarmCfg_nxt;
  logic [15:0] pad_r;
  logic [15:0] pad_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        pinOut_r;
  logic        pinOut_nxt;
  logic        pinOe_r;
  logic        pinOe_nxt;

  // Window plumbing
  logic [1:0]  valuePtr;
  logic [1:0]  alarmPtr;
  logic        unlockOpen;
  logic        timeWrHi;
  logic        timeWrLo;
  logic        alarmWrHi;
  logic        alarmWrLo;
  logic [15:0] timeRaw;
  logic [15:0] alarmRaw;
  logic [15:0] timeWinRd;
  logic [15:0] alarmWinRd;
  logic [15:0] calibRd;
  logic        timeStep;
  logic        alarmStep;
  logic        writeEnable;
  logic        keyWrite;
  logic        timeHiAcc;
  logic        timeLoAcc;
  logic        alarmHiAcc;
  logic        alarmLoAcc;
  logic [15:0] regRd;
  logic        pinSrc;

  assign setupRead   = psel & ~penable & ~pwrite;
  assign accDone     = psel & penable;
  assign wrDone      = accDone & pwrite;
  assign rdDone      = accDone & ~pwrite;

  assign selCalib    = hitOfs(paddr, rtcw_pkg::OFS_CALIB);
  assign selAlarmCfg = hitOfs(paddr, rtcw_pkg::OFS_ALARM_CFG);
  assign selTimeWin  = hitOfs(paddr, rtcw_pkg::OFS_TIME_WIN);
  assign selAlarmWin = hitOfs(paddr, rtcw_pkg::OFS_ALARM_WIN);
  assign selKey      = hitOfs(paddr, rtcw_pkg::OFS_KEY);
  assign selPad      = hitOfs(paddr, rtcw_pkg::OFS_PAD);
  // Unmapped addresses answer with an error and read as zero
  assign mapped      = selCalib | selAlarmCfg | selTimeWin | selAlarmWin | selKey | selPad;
  assign keyWrite    = wrDone & selKey & pstrb[0];

  // Zero wait states: read data is captured during the setup cycle
  assign pready      = penable;
  assign pslverr     = accDone & ~mapped;
  assign prdata      = prdata_r;

  assign valuePtr    = calib_r[rtcw_pkg::PTR_MSB:rtcw_pkg::PTR_LSB];
  assign alarmPtr    = alarmCfg_r[rtcw_pkg::PTR_MSB:rtcw_pkg::PTR_LSB];
  assign writeEnable = calib_r[rtcw_pkg::CAL_WREN_BIT];

  // Key writes use the low byte only; any other completed transfer closes the window
  rtcw_unlock_seq u_unlock (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .keyWrite   (keyWrite),
    .keyData    (pwdata[7:0]),
    .xferDone   (accDone),
    .windowOpen (unlockOpen)
  );

  // Completed window writes per byte lane; lane 1 carries the high byte
  always_comb begin
    timeHiAcc  = wrDone & selTimeWin & pstrb[1];
    timeLoAcc  = wrDone & selTimeWin & pstrb[0];
    alarmHiAcc = wrDone & selAlarmWin & pstrb[1];
    alarmLoAcc = wrDone & selAlarmWin & pstrb[0];
  end

  // Time bank: pointer 11 has only the year in the low byte
  always_comb begin
    timeWrHi = timeHiAcc & writeEnable
               & (valuePtr != rtcw_pkg::PTR_TOP);
    timeWrLo = timeLoAcc & writeEnable;
  end

  rtcw_byte_bank u_time_bank (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .ptr      (valuePtr),
    .wrHi     (timeWrHi),
    .wrLo     (timeWrLo),
    .wrData   (pwdata[15:0]),
    .rdData   (timeRaw),
    .contents (timeValues)
  );

  // Alarm bank: pointer 11 selects nothing
  always_comb begin
    alarmWrHi = alarmHiAcc & (alarmPtr != rtcw_pkg::PTR_TOP);
    alarmWrLo = alarmLoAcc & (alarmPtr != rtcw_pkg::PTR_TOP);
  end

  rtcw_byte_bank u_alarm_bank (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .ptr      (alarmPtr),
    .wrHi     (alarmWrHi),
    .wrLo     (alarmWrLo),
    .wrData   (pwdata[15:0]),
    .rdData   (alarmRaw),
    .contents (alarmValues)
  );

  // Window read views with the unimplemented slots forced to zero
  always_comb begin
    timeWinRd  = timeRaw;
    alarmWinRd = alarmRaw;
    if (valuePtr == rtcw_pkg::PTR_TOP) begin
      timeWinRd[15:8] = 8'h00;
    end
    if (alarmPtr == rtcw_pkg::PTR_TOP) begin
      alarmWinRd = 16'h0000;
    end
  end

  // A read steps the pointer regardless of lanes; writes only via the high lane
  // A locked write still steps, so a walk made only to read stays in step
  always_comb begin
    timeStep  = winStep(rdDone & selTimeWin, wrDone & selTimeWin,
                        pstrb[1]);
    alarmStep = winStep(rdDone & selAlarmWin, wrDone & selAlarmWin,
                        pstrb[1]);
  end

  // Calibration and configuration register
  always_comb begin
    calib_nxt = calib_r;
    if (wrDone & selCalib) begin
      calib_nxt = rtcw_pkg::mergeWrite(calib_r, pwdata[15:0], pstrb[1:0],
                                       rtcw_pkg::CAL_WMASK);
      // Clearing the write enable is always allowed; setting needs the key window
      if (!writeEnable && !unlockOpen) begin
        calib_nxt[rtcw_pkg::CAL_WREN_BIT] = 1'b0;
      end
      // Module enable changes only while time writes are unlocked
      if (!writeEnable) begin
        calib_nxt[rtcw_pkg::CAL_EN_BIT] = calib_r[rtcw_pkg::CAL_EN_BIT];
      end
    end else if (timeStep) begin
      calib_nxt[rtcw_pkg::PTR_MSB:rtcw_pkg::PTR_LSB] =
        rtcw_pkg::ptrStep(valuePtr);
    end
  end

  // Only the power-on reset reaches this register; softRst is ignored here
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      calib_r <= rtcw_pkg::CAL_RST;
    end else begin
      calib_r <= calib_nxt;
    end
  end

  // Alarm configuration register
  always_comb begin
    alarmCfg_nxt = alarmCfg_r;
    if (wrDone & selAlarmCfg) begin
      alarmCfg_nxt = rtcw_pkg::mergeWrite(alarmCfg_r, pwdata[15:0], pstrb[1:0],
                                          rtcw_pkg::ALM_WMASK);
    end else if (alarmStep) begin
      alarmCfg_nxt[rtcw_pkg::PTR_MSB:rtcw_pkg::PTR_LSB] =
        rtcw_pkg::ptrStep(alarmPtr);
    end
  end

  // The other reset source clears alarm and pad settings, never the calibration register
  always_ff @(posedge clk_sys) begin
    if (rst || softRst) begin
      alarmCfg_r <= rtcw_pkg::ALM_RST;
    end else begin
      alarmCfg_r <= alarmCfg_nxt;
    end
  end

  // Pad configuration register
  always_comb begin
    pad_nxt = pad_r;
    if (wrDone & selPad) begin
      pad_nxt = rtcw_pkg::mergeWrite(pad_r, pwdata[15:0], pstrb[1:0],
                                     rtcw_pkg::PAD_WMASK);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || softRst) begin
      pad_r <= rtcw_pkg::PAD_RST;
    end else begin
      pad_r <= pad_nxt;
    end
  end

  // Status bits are live inputs, never stored,
  // so a register write can neither set nor mask them
  always_comb begin
    calibRd = calib_r;
    calibRd[rtcw_pkg::CAL_SYNC_BIT] = syncBusy;
    calibRd[rtcw_pkg::CAL_HALF_BIT] = halfSec;
  end

  // Register read view at the current address; unmapped and key reads give zero
  always_comb begin
    regRd = 16'h0000;
    if (selCalib) begin
      regRd = calibRd;
    end else if (selAlarmCfg) begin
      regRd = alarmCfg_r;
    end else if (selTimeWin) begin
      regRd = timeWinRd;
    end else if (selAlarmWin) begin
      regRd = alarmWinRd;
    end else if (selPad) begin
      regRd = pad_r;
    end
  end

  // Read data is taken at the setup edge, so the pointer step at the access edge
  // cannot change the word already on the bus
  always_comb begin
    prdata_nxt = prdata_r;
    if (setupRead) begin
      prdata_nxt = {16'h0000, regRd};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata_r <= 32'h0000_0000;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  // Seconds clock or alarm pulse, chosen by the pad select bit
  always_comb begin
    pinSrc = pad_r[rtcw_pkg::PAD_SEL_BIT] ? secClk : alarmPulse;
  end

  // Output pin: one flop of latency keeps the pad glitch free
  always_comb begin
    pinOe_nxt  = calib_r[rtcw_pkg::CAL_OE_BIT];
    pinOut_nxt = 1'b0;
    if (calib_r[rtcw_pkg::CAL_OE_BIT]) begin
      pinOut_nxt = pinSrc;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pinOut_r <= 1'b0;
      pinOe_r  <= 1'b0;
    end else begin
      pinOut_r <= pinOut_nxt;
      pinOe_r  <= pinOe_nxt;
    end
  end

  assign pinOut      = pinOut_r;
  assign pinOe       = pinOe_r;
  assign rtcEnable   = calib_r[rtcw_pkg::CAL_EN_BIT];
  assign driftCal    = calib_r[rtcw_pkg::DRIFT_MSB:0];
  assign alarmConfig = alarmCfg_r;

endmodule // rtcw_window_access

/* rtl/rtcw_pkg.sv */
package rtcw_pkg;

  // Register byte offsets on the APB
  localparam logic [7:0]  OFS_CALIB     = 8'h00;
  localparam logic [7:0]  OFS_ALARM_CFG = 8'h04;
  localparam logic [7:0]  OFS_TIME_WIN  = 8'h08;
  localparam logic [7:0]  OFS_ALARM_WIN = 8'h0C;
  localparam logic [7:0]  OFS_KEY       = 8'h10;
  localparam logic [7:0]  OFS_PAD       = 8'h14;

  // Calibration and configuration fields
  localparam int unsigned CAL_EN_BIT    = 15;
  localparam int unsigned CAL_WREN_BIT  = 13;
  localparam int unsigned CAL_SYNC_BIT  = 12;
  localparam int unsigned CAL_HALF_BIT  = 11;
  localparam int unsigned CAL_OE_BIT    = 10;
  localparam int unsigned PTR_LSB       = 8;
  localparam int unsigned PTR_MSB       = 9;
  localparam int unsigned DRIFT_MSB     = 7;
  localparam logic [15:0] CAL_WMASK     = 16'hA7FF;
  localparam logic [15:0] CAL_RST       = 16'h0000;

  // Alarm configuration, all bits writable
  localparam logic [15:0] ALM_WMASK     = 16'hFFFF;
  localparam logic [15:0] ALM_RST       = 16'h0000;

  // Pad configuration
  localparam int unsigned PAD_SEL_BIT   = 1;
  localparam logic [15:0] PAD_WMASK     = 16'h0003;
  localparam logic [15:0] PAD_RST       = 16'h0000;

  // Unlock key sequence
  localparam logic [7:0]  KEY_FIRST     = 8'h55;
  localparam logic [7:0]  KEY_SECOND    = 8'hAA;

  // Window pointer codes
  localparam logic [1:0]  PTR_FLOOR     = 2'h0;
  localparam logic [1:0]  PTR_TOP       = 2'h3;

  localparam int unsigned BANK_DEPTH    = 8;

  typedef enum logic [1:0] {
    UNL_IDLE  = 2'b00,
    UNL_ARMED = 2'b01,
    UNL_OPEN  = 2'b11
  } rtcw_unlock_type;

  // Pointer step that sticks at the floor code
  function automatic logic [1:0] ptrStep(input logic [1:0] ptr);
    return (ptr == PTR_FLOOR) ? PTR_FLOOR : ptr - 2'h1;
  endfunction

  // Merge a write into a 16-bit register by strobes and writable mask
  function automatic logic [15:0] mergeWrite(input logic [15:0] old,
                                             input logic [15:0] data,
                                             input logic [1:0]  strb,
                                             input logic [15:0] wmask);
    logic [15:0] laneMask;
    laneMask = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
    return (old & ~laneMask) | (data & laneMask);
  endfunction

endpackage

/* rtl/rtcw_byte_bank.sv */
`timescale 1ns/1ns
module rtcw_byte_bank (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [1:0]  ptr,
  input  wire logic        wrHi,
  input  wire logic        wrLo,
  input  wire logic [15:0] wrData,
  output logic      [15:0] rdData,
  output logic      [63:0] contents
);

  // Entry index is {pointer, lane}; lane 1 is the high byte
  logic [7:0] mem_r   [rtcw_pkg::BANK_DEPTH];
  logic [7:0] mem_nxt [rtcw_pkg::BANK_DEPTH];

  always_comb begin
    for (int i = 0; i < rtcw_pkg::BANK_DEPTH; i++) begin
      mem_nxt[i] = mem_r[i];
    end
    if (wrHi) begin
      mem_nxt[{ptr, 1'b1}] = wrData[15:8];
    end
    if (wrLo) begin
      mem_nxt[{ptr, 1'b0}] = wrData[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < rtcw_pkg::BANK_DEPTH; i++) begin
      mem_r[i] <= rst ? 8'h00 : mem_nxt[i];
    end
  end

  assign rdData = {mem_r[{ptr, 1'b1}], mem_r[{ptr, 1'b0}]};

  always_comb begin
    for (int i = 0; i < rtcw_pkg::BANK_DEPTH; i++) begin
      contents[8*i +: 8] = mem_r[i];
    end
  end

endmodule // rtcw_byte_bank

/* rtl/rtcw_unlock_seq.sv */
`timescale 1ns/1ns
module rtcw_unlock_seq (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       keyWrite,
  input  wire logic [7:0] keyData,
  input  wire logic       xferDone,
  output logic            windowOpen
);

  rtcw_pkg::rtcw_unlock_type state_r;
  rtcw_pkg::rtcw_unlock_type state_nxt;

  // The window lasts for exactly one bus transfer after the second key
  always_comb begin
    state_nxt = state_r;
    if (keyWrite) begin
      if (keyData == rtcw_pkg::KEY_FIRST) begin
        state_nxt = rtcw_pkg::UNL_ARMED;
      end else if (keyData == rtcw_pkg::KEY_SECOND && state_r == rtcw_pkg::UNL_ARMED) begin
        state_nxt = rtcw_pkg::UNL_OPEN;
      end else begin
        state_nxt = rtcw_pkg::UNL_IDLE;
      end
    end else if (xferDone) begin
      state_nxt = rtcw_pkg::UNL_IDLE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= rtcw_pkg::UNL_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_comb begin
    unique case (state_r)
      rtcw_pkg::UNL_IDLE:  windowOpen = 1'b0;
      rtcw_pkg::UNL_ARMED: windowOpen = 1'b0;
      rtcw_pkg::UNL_OPEN:  windowOpen = 1'b1;
      default:             windowOpen = 1'b0;
    endcase
  end

endmodule // rtcw_unlock_seq

/* test/rtcw_window_access_chk.sv */
`timescale 1ns/1ns
module rtcw_window_access_chk (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        softRst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        secClk,
  input wire logic        alarmPulse,
  input wire logic        pinOut,
  input wire logic        pinOe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [1:0] valPtr_r, valPtr_nxt, almPtr_r, almPtr_nxt;
  logic       acc, rdAcc;
  assign acc   = psel && penable && pready;
  assign rdAcc = acc && !pwrite;
  // Shadow pointers rebuilt from bus traffic and soft reset only, so a stuck design pointer shows
  always_comb begin
    valPtr_nxt = valPtr_r;
    almPtr_nxt = almPtr_r;
    if (acc && pwrite && pstrb[1] && paddr == rtcw_pkg::OFS_CALIB) valPtr_nxt = pwdata[9:8];
    if (acc && (!pwrite || pstrb[1]) && paddr == rtcw_pkg::OFS_TIME_WIN && valPtr_r != 2'h0)
      valPtr_nxt = valPtr_r - 2'h1;
    if (acc && pwrite && pstrb[1] && paddr == rtcw_pkg::OFS_ALARM_CFG) almPtr_nxt = pwdata[9:8];
    if (acc && (!pwrite || pstrb[1]) && paddr == rtcw_pkg::OFS_ALARM_WIN && almPtr_r != 2'h0)
      almPtr_nxt = almPtr_r - 2'h1;
    if (softRst) almPtr_nxt = 2'h0;
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      valPtr_r <= 2'h0;
      almPtr_r <= 2'h0;
    end else begin
      valPtr_r <= valPtr_nxt;
      almPtr_r <= almPtr_nxt;
    end
  end
  AST_VAL_PTR: assert property (rdAcc && paddr == rtcw_pkg::OFS_CALIB
    |-> prdata[9:8] == valPtr_r)
    else $error("value pointer differs from shadow");
  AST_ALM_PTR: assert property (rdAcc && paddr == rtcw_pkg::OFS_ALARM_CFG
    |-> prdata[9:8] == almPtr_r)
    else $error("alarm pointer differs from shadow");
  AST_PIN_GATE: assert property (pinOut |-> pinOe)
    else $error("pin driven while output disabled");
  AST_PIN_SRC: assert property (pinOut |-> $past(secClk) || $past(alarmPulse))
    else $error("pin high without a source");
  AST_READY: assert property (psel |-> pready == penable)
    else $error("ready not tied to access phase");
  AST_UNMAPPED: assert property (acc && paddr > 8'h14 |-> pslverr ##1 !pslverr)
    else $error("unmapped access error wrong");
  AST_MAPPED: assert property (acc && paddr <= 8'h14 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access flagged");
  AST_UPPER: assert property (rdAcc |-> prdata[31:16] == 16'h0 && (!pslverr || prdata == 32'h0))
    else $error("read data upper half or error data nonzero");
  AST_KEY_RD: assert property (rdAcc && paddr == rtcw_pkg::OFS_KEY |-> prdata == 32'h0)
    else $error("key register read nonzero");
  cover property (rdAcc && paddr == rtcw_pkg::OFS_TIME_WIN);
  cover property (acc && pwrite && paddr == rtcw_pkg::OFS_ALARM_WIN);
  cover property (pinOut);
endmodule // rtcw_window_access_chk

bind rtcw_window_access rtcw_window_access_chk u_chk (.clk_sys(clk_sys), .rst(rst),
  .softRst(softRst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .secClk(secClk), .alarmPulse(alarmPulse), .pinOut(pinOut), .pinOe(pinOe));

/* test/tb_calendar_register_window_access.sv */
`timescale 1ns/1ns
module tb_calendar_register_window_access;
  logic        clk_sys, rst, softRst, psel, penable, pwrite, pready, pslverr, lastErr;
  logic        secClk, alarmPulse, halfSec, syncBusy, pinOut, pinOe, rtcEnable;
  logic [7:0]  paddr, driftCal;
  logic [15:0] alarmConfig;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, rdData;
  logic [63:0] timeValues, alarmValues;
  int          err_total = 0;
  int          checked = 0;

  rtcw_window_access DUT (.clk_sys(clk_sys), .rst(rst), .softRst(softRst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .secClk(secClk),
    .alarmPulse(alarmPulse), .halfSec(halfSec), .syncBusy(syncBusy), .rtcEnable(rtcEnable),
    .driftCal(driftCal), .alarmConfig(alarmConfig), .timeValues(timeValues),
    .alarmValues(alarmValues),
    .pinOut(pinOut), .pinOe(pinOe));

  initial begin
    clk_sys = 1'h0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                      input logic [1:0] s);
    int n;
    n = 0;
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {16'h0, d};
    pstrb   <= {2'h0, s};
    @(posedge clk_sys);
    penable <= 1'h1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) err_total++;
    rdData  = prdata;
    lastErr = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] s);
    xfer(1'h1, a, d, s);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'h0, a, 16'h0, 2'h3);
    chk({32'h0, rdData}, {32'h0, e});
  endtask

  task automatic t_reset;
    rd(rtcw_pkg::OFS_CALIB, 32'h0);
    rd(rtcw_pkg::OFS_ALARM_CFG, 32'h0);
    rd(rtcw_pkg::OFS_PAD, 32'h0);
    rd(rtcw_pkg::OFS_KEY, 32'h0);
    rd(8'h18, 32'h0);
    chk({63'h0, lastErr}, 64'h1);
    $display("reset test done");
  endtask

  task automatic t_lock;
    wr(rtcw_pkg::OFS_CALIB, 16'h8300, 2'h3);
    chk({63'h0, rtcEnable}, 64'h0);
    wr(rtcw_pkg::OFS_TIME_WIN, 16'h1234, 2'h3);
    chk(timeValues, 64'h0);
    rd(rtcw_pkg::OFS_CALIB, 32'h0200);
    wr(rtcw_pkg::OFS_CALIB, 16'h2300, 2'h3);
    rd(rtcw_pkg::OFS_CALIB, 32'h0300);
    wr(rtcw_pkg::OFS_KEY, 16'h0055, 2'h1);
    wr(rtcw_pkg::OFS_KEY, 16'h00AA, 2'h1);
    rd(rtcw_pkg::OFS_PAD, 32'h0);
    wr(rtcw_pkg::OFS_CALIB, 16'h2300, 2'h3);
    rd(rtcw_pkg::OFS_CALIB, 32'h0300);
    $display("lock test done");
  endtask

  task automatic t_unlock;
    logic [15:0] e [5] = '{16'h0024, 16'h1231, 16'h0323, 16'h5958, 16'h5958};
    wr(rtcw_pkg::OFS_KEY, 16'h0055, 2'h1);
    wr(rtcw_pkg::OFS_KEY, 16'h00AA, 2'h1);
    wr(rtcw_pkg::OFS_CALIB, 16'h2300, 2'h3);
    rd(rtcw_pkg::OFS_CALIB, 32'h2300);
    wr(rtcw_pkg::OFS_CALIB, 16'hA300, 2'h3);
    chk({63'h0, rtcEnable}, 64'h1);
    wr(rtcw_pkg::OFS_TIME_WIN, 16'h0024, 2'h1);
    rd(rtcw_pkg::OFS_CALIB, 32'hA300);
    for (int i = 0; i < 5; i++) wr(rtcw_pkg::OFS_TIME_WIN, e[i], 2'h3);
    rd(rtcw_pkg::OFS_CALIB, 32'hA000);
    chk(timeValues, 64'h0024_1231_0323_5958);
    wr(rtcw_pkg::OFS_CALIB, 16'h2300, 2'h3);
    for (int i = 0; i < 5; i++) rd(rtcw_pkg::OFS_TIME_WIN, {16'h0, e[i]});
    wr(rtcw_pkg::OFS_CALIB, 16'h0000, 2'h3);
    rd(rtcw_pkg::OFS_CALIB, 32'h0);
    wr(rtcw_pkg::OFS_TIME_WIN, 16'h0000, 2'h3);
    chk(timeValues, 64'h0024_1231_0323_5958);
    $display("unlock test done");
  endtask

  task automatic t_alarm;
    wr(rtcw_pkg::OFS_ALARM_CFG, 16'h0200, 2'h3);
    chk({48'h0, alarmConfig}, 64'h0200);
    wr(rtcw_pkg::OFS_ALARM_WIN, 16'h1231, 2'h3);
    wr(rtcw_pkg::OFS_ALARM_WIN, 16'h0023, 2'h1);
    rd(rtcw_pkg::OFS_ALARM_CFG, 32'h0100);
    wr(rtcw_pkg::OFS_ALARM_WIN, 16'h0300, 2'h2);
    wr(rtcw_pkg::OFS_ALARM_WIN, 16'h5958, 2'h3);
    rd(rtcw_pkg::OFS_ALARM_CFG, 32'h0);
    chk(alarmValues, 64'h0000_1231_0323_5958);
    wr(rtcw_pkg::OFS_ALARM_CFG, 16'h0300, 2'h3);
    wr(rtcw_pkg::OFS_ALARM_WIN, 16'hFFFF, 2'h3);
    chk(alarmValues, 64'h0000_1231_0323_5958);
    rd(rtcw_pkg::OFS_ALARM_WIN, 32'h1231);
    rd(rtcw_pkg::OFS_ALARM_CFG, 32'h0100);
    wr(rtcw_pkg::OFS_ALARM_CFG, 16'h0300, 2'h3);
    rd(rtcw_pkg::OFS_ALARM_WIN, 32'h0);
    rd(rtcw_pkg::OFS_ALARM_CFG, 32'h0200);
    $display("alarm test done");
  endtask

  task automatic pin(input logic s, input logic a, input logic [1:0] e);
    secClk     <= s;
    alarmPulse <= a;
    repeat (2) @(posedge clk_sys);
    chk({62'h0, pinOe, pinOut}, {62'h0, e});
  endtask

  task automatic t_pin;
    wr(rtcw_pkg::OFS_PAD, 16'h0002, 2'h1);
    wr(rtcw_pkg::OFS_CALIB, 16'h0400, 2'h3);
    pin(1'h1, 1'h0, 2'h3);
    pin(1'h0, 1'h1, 2'h2);
    wr(rtcw_pkg::OFS_PAD, 16'h0000, 2'h1);
    pin(1'h0, 1'h1, 2'h3);
    pin(1'h1, 1'h0, 2'h2);
    wr(rtcw_pkg::OFS_CALIB, 16'h0000, 2'h3);
    pin(1'h0, 1'h1, 2'h0);
    $display("pin test done");
  endtask

  task automatic t_soft;
    wr(rtcw_pkg::OFS_PAD, 16'h0003, 2'h1);
    wr(rtcw_pkg::OFS_ALARM_CFG, 16'h0300, 2'h3);
    wr(rtcw_pkg::OFS_CALIB, 16'h04A5, 2'h3);
    softRst <= 1'h1;
    @(posedge clk_sys);
    softRst <= 1'h0;
    @(posedge clk_sys);
    rd(rtcw_pkg::OFS_PAD, 32'h0);
    rd(rtcw_pkg::OFS_ALARM_CFG, 32'h0);
    chk({56'h0, driftCal}, 64'hA5);
    halfSec  <= 1'h1;
    syncBusy <= 1'h1;
    rd(rtcw_pkg::OFS_CALIB, 32'h1CA5);
    halfSec  <= 1'h0;
    syncBusy <= 1'h0;
    $display("soft reset test done");
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    rst = 1'h1;
    softRst = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    secClk = 1'h0;
    alarmPulse = 1'h0;
    halfSec = 1'h0;
    syncBusy = 1'h0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'h0;
    @(posedge clk_sys);
    t_reset;
    t_lock;
    t_unlock;
    t_alarm;
    t_pin;
    t_soft;
    print_verdict;
  end

  // Whole run is about two hundred cycles; this bound only cuts a hang
  initial begin
    #20000;
    err_total++;
    print_verdict;
  end
endmodule // tb_calendar_register_window_access
